// File: pkg/sts_map.svh
/*
 * Numeric constants of the state trigger sequencer: widths, encodings, limits and timing.
 * Assumes inclusion by the package and by the design, once per compilation unit.
 */
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

`define STS_NWORDS       7
`define STS_DATA_W       35
`define STS_NCLK         3
`define STS_NBLK         2
`define STS_DLY_W        16
`define STS_TRIGCNT_W    16
`define STS_SAMPLES_W    8
`define STS_REPEAT_W     10
`define STS_REPEAT_MAX   10'h200
`define STS_PIPE_STAGES  3
`define STS_CLK_NS       50
`define STS_MATCH_MIN_NS 60
`define STS_MATCH_MIN_CYC ((`STS_MATCH_MIN_NS + `STS_CLK_NS - 1) / `STS_CLK_NS)
`define STS_STR_W        2

`define STS_TMODE_PARALLEL 2'h0
`define STS_TMODE_SEQ      2'h1
`define STS_TMODE_IMMSEQ   2'h2

`define STS_UNIT_SAMPLES 2'h0
`define STS_UNIT_WORDS   2'h1
`define STS_UNIT_TIME    2'h2

`define STS_OPEN_WORD    1'h0
`define STS_OPEN_START   1'h1

`define STS_CLOSE_WORD   2'h0
`define STS_CLOSE_WDLY   2'h1
`define STS_CLOSE_END    2'h2

`define STS_STORE_ALL    2'h0
`define STS_STORE_WTHEN  2'h1
`define STS_STORE_WONLY  2'h2
`define STS_STORE_WN     2'h3

`endif

// File: pkg/sts_pkg.sv
/*
 * Types of the state trigger sequencer: per-word, trigger, block and counter setup.
 * Assumes sts_map.svh is on the include path.
 */
`include "sts_map.svh"

package sts_pkg;

	typedef struct packed {
		logic [`STS_DATA_W-1:0] value;
		logic [`STS_DATA_W-1:0] care;
		logic                   is_false;
		logic [`STS_DLY_W-1:0]  delay;
		logic                   match_out;
	} sts_word_t;

	typedef struct packed {
		logic [1:0]                mode;
		logic [2:0]                last_idx;
		logic [`STS_TRIGCNT_W-1:0] trig_count;
		logic                      ext_edge;
		logic [1:0]                dly_unit;
		logic [2:0]                dly_word;
		logic [`STS_DLY_W-1:0]     dly_count;
		logic [`STS_NCLK-1:0]      clk_sel;
		logic                      clk_fall;
	} sts_trig_t;

	typedef struct packed {
		logic                      enable;
		logic                      open_src;
		logic [2:0]                open_word;
		logic [1:0]                close_src;
		logic [2:0]                close_word;
		logic [1:0]                store;
		logic [2:0]                store_word;
		logic [`STS_SAMPLES_W-1:0] n_samples;
		logic [`STS_REPEAT_W-1:0]  max_repeat;
	} sts_blk_t;

	typedef struct packed {
		logic       blk;
		logic [1:0] unit;
		logic [2:0] word;
	} sts_cnt_t;

	typedef enum logic [3:0] {
		STS_IDLE  = 4'h1,
		STS_ARM   = 4'h2,
		STS_DELAY = 4'h4,
		STS_DONE  = 4'h8
	} sts_state_t;

endpackage

// File: verilog/sts_sequencer.sv
/*
 * State trigger sequencer: word compare, trigger sequencing, delays, match/run outputs,
 * selective acquisition blocks and interval counter.
 * Assumes sut pins arrive asynchronous to ref_clk and that the clock edge rate is well
 * below ref_clk; setup comes from quasi-static configuration ports.
 */
`timescale 1ns/1ps
`include "sts_map.svh"

module sts_sequencer #(
	parameter int DATA_W = `STS_DATA_W
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          clk_en,
	input  wire logic [`STS_NCLK-1:0]          sut_clk,
	input  wire logic [DATA_W-1:0]             sut_data,
	input  wire logic                          ext_trig,
	input  wire logic                          stop_btn,
	input  wire logic                          start,
	input  wire sts_pkg::sts_word_t [`STS_NWORDS-1:0] word_cfg,
	input  wire sts_pkg::sts_trig_t            trig_cfg,
	input  wire sts_pkg::sts_blk_t [`STS_NBLK-1:0]    blk_cfg,
	input  wire sts_pkg::sts_cnt_t             cnt_cfg,
	output logic                               match_out,
	output logic                               run_out,
	output logic                               triggered,
	output logic                               store_valid,
	output logic [DATA_W-1:0]                  store_data,
	output logic [`STS_DLY_W-1:0]              interval_count
);

	// two-flop synchronisers, three flops for clocks and external trigger; stage one feeds stage two only
	logic [`STS_NCLK-1:0] clk_s1_reg, clk_s2_reg, clk_s3_reg;
	logic [DATA_W-1:0]    dat_s1_reg, dat_s2_reg;
	logic                 ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic                 stp_s1_reg, stp_s2_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clk_s1_reg <= '0;
			clk_s2_reg <= '0;
			clk_s3_reg <= '0;
			dat_s1_reg <= '0;
			dat_s2_reg <= '0;
			ext_s1_reg <= 1'h0;
			ext_s2_reg <= 1'h0;
			ext_s3_reg <= 1'h0;
			stp_s1_reg <= 1'h0;
			stp_s2_reg <= 1'h0;
		end else if (clk_en) begin
			clk_s1_reg <= sut_clk;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			dat_s1_reg <= sut_data;
			dat_s2_reg <= dat_s1_reg;
			ext_s1_reg <= ext_trig;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			stp_s1_reg <= stop_btn;
			stp_s2_reg <= stp_s1_reg;
		end
	end

	function automatic logic word_hit(input logic [DATA_W-1:0] d, input sts_pkg::sts_word_t w);
		word_hit = ((((d ^ w.value[DATA_W-1:0]) & w.care[DATA_W-1:0]) == '0) ^ w.is_false);
	endfunction

	// active edge of any selected state clock
	logic [`STS_NCLK-1:0] edges;
	logic                 smp;
	assign edges = trig_cfg.clk_fall ? (clk_s3_reg & ~clk_s2_reg) : (~clk_s3_reg & clk_s2_reg);
	assign smp   = clk_en && ((edges & trig_cfg.clk_sel) != '0);

	logic [`STS_NWORDS-1:0] hit;
	always_comb begin
		for (int i = 0; i < `STS_NWORDS; i++) begin
			hit[i] = word_hit(dat_s2_reg, word_cfg[i]);
		end
	end

	// external enable: level, or edge latched until the next sample
	logic ext_pend_reg, ext_ok;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ext_pend_reg <= 1'h0;
		end else if (clk_en) begin
			if (ext_s2_reg && !ext_s3_reg) begin
				ext_pend_reg <= 1'h1;
			end else if (smp) begin
				ext_pend_reg <= 1'h0;
			end
		end
	end
	assign ext_ok = trig_cfg.ext_edge ? (ext_pend_reg || (ext_s2_reg && !ext_s3_reg))
	                                   : ext_s2_reg;

	sts_pkg::sts_state_t       st_reg;
	logic [2:0]                step_reg;
	logic [`STS_DLY_W-1:0]     wdly_reg;
	logic                      imm_wait_reg;
	logic [`STS_TRIGCNT_W-1:0] tcnt_reg;
	logic [`STS_DLY_W-1:0]     dly_reg;
	logic                      final_idx_hit, final_ok, stop_now, dly_tick;
	logic                      stopped_reg;
	logic [2:0]                fidx;

	always_comb begin
		final_idx_hit = 1'h0;
		fidx          = trig_cfg.last_idx;
		if (trig_cfg.mode == `STS_TMODE_PARALLEL) begin
			for (int i = 0; i < `STS_NWORDS; i++) begin
				if (i <= int'(trig_cfg.last_idx) && hit[i]) begin
					final_idx_hit = 1'h1;
				end
			end
		end else begin
			final_idx_hit = (step_reg == trig_cfg.last_idx) && (wdly_reg == '0) && hit[fidx];
		end
	end

	// all don't-care final word: external input alone; else it qualifies
	assign final_ok = (word_cfg[fidx].care[DATA_W-1:0] == '0) ? ext_ok
	                                                          : (final_idx_hit && ext_ok);
	assign stop_now = stp_s2_reg && clk_en;

	always_comb begin
		case (trig_cfg.dly_unit)
			`STS_UNIT_SAMPLES: dly_tick = smp;
			`STS_UNIT_WORDS:   dly_tick = smp && hit[trig_cfg.dly_word];
			default:           dly_tick = clk_en;
		endcase
	end

	// trigger state machine with preset trigger count and trigger delay
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg      <= sts_pkg::STS_IDLE;
			tcnt_reg    <= '0;
			dly_reg     <= '0;
			stopped_reg <= 1'h0;
		end else if (clk_en) begin
			case (st_reg)
				sts_pkg::STS_IDLE: begin
					if (start) begin
						st_reg      <= sts_pkg::STS_ARM;
						tcnt_reg    <= '0;
						stopped_reg <= 1'h0;
					end
				end
				sts_pkg::STS_ARM: begin
					if (stop_now) begin
						// stopped before any trigger: done, but not triggered
						st_reg      <= sts_pkg::STS_DONE;
						stopped_reg <= 1'h1;
					end else if (smp && final_ok) begin
						if (tcnt_reg + 1'h1 >= trig_cfg.trig_count) begin
							st_reg  <= (trig_cfg.dly_count == '0) ? sts_pkg::STS_DONE
							                                      : sts_pkg::STS_DELAY;
							dly_reg <= trig_cfg.dly_count;
						end else begin
							tcnt_reg <= tcnt_reg + 1'h1;
						end
					end
				end
				sts_pkg::STS_DELAY: begin
					if (stop_now || (dly_tick && dly_reg == `STS_DLY_W'h1)) begin
						st_reg <= sts_pkg::STS_DONE;
					end else if (dly_tick) begin
						dly_reg <= dly_reg - 1'h1;
					end
				end
				sts_pkg::STS_DONE: begin
					if (start) begin
						st_reg      <= sts_pkg::STS_ARM;
						tcnt_reg    <= '0;
						stopped_reg <= 1'h0;
					end
				end
				default: st_reg <= sts_pkg::STS_IDLE;
			endcase
		end
	end

	logic armed, delay_done, acq_start, acq_end;
	assign armed      = (st_reg == sts_pkg::STS_ARM);
	assign acq_start  = clk_en && start && !armed && (st_reg != sts_pkg::STS_DELAY);
	assign acq_end    = clk_en && (st_reg != sts_pkg::STS_DONE) && (st_reg != sts_pkg::STS_IDLE)
	                    && (stop_now || (st_reg == sts_pkg::STS_DELAY && dly_tick
	                    && dly_reg == `STS_DLY_W'h1) || (armed && smp && final_ok
	                    && tcnt_reg + 1'h1 >= trig_cfg.trig_count && trig_cfg.dly_count == '0));
	assign delay_done = acq_end && !stop_now;

	// sequence stepping with per-word delay
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			step_reg     <= 3'h0;
			wdly_reg     <= '0;
			imm_wait_reg <= 1'h0;
		end else if (clk_en) begin
			if (!armed || trig_cfg.mode == `STS_TMODE_PARALLEL) begin
				step_reg     <= 3'h0;
				wdly_reg     <= '0;
				imm_wait_reg <= 1'h0;
			end else if (smp) begin
				if (wdly_reg != '0) begin
					wdly_reg <= wdly_reg - 1'h1;
				end else if (step_reg != trig_cfg.last_idx && hit[step_reg]) begin
					step_reg     <= step_reg + 3'h1;
					wdly_reg     <= word_cfg[step_reg].delay;
					imm_wait_reg <= 1'h1;
				end else if (trig_cfg.mode == `STS_TMODE_IMMSEQ && imm_wait_reg
				             && !(step_reg == trig_cfg.last_idx && final_ok)) begin
					step_reg     <= 3'h0;
					imm_wait_reg <= 1'h0;
				end
			end
		end
	end

	assign triggered = (st_reg == sts_pkg::STS_DELAY) || (st_reg == sts_pkg::STS_DONE && !stopped_reg);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_out <= 1'h0;
		end else if (clk_en) begin
			if (acq_start) begin
				run_out <= 1'h1;
			end else if (acq_end) begin
				run_out <= 1'h0;
			end
		end
	end

	// match output: designated hit shown after three further samples, stretched
	logic                         des_hit;
	logic [`STS_PIPE_STAGES-1:0]  mpipe_reg;
	logic                         mlvl_reg;
	logic [`STS_STR_W-1:0]        mstr_reg;
	always_comb begin
		des_hit = 1'h0;
		for (int i = 0; i < `STS_NWORDS; i++) begin
			if (word_cfg[i].match_out && hit[i]) begin
				des_hit = 1'h1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mpipe_reg <= '0;
			mlvl_reg  <= 1'h0;
		end else if (smp) begin
			mpipe_reg <= {mpipe_reg[`STS_PIPE_STAGES-2:0], des_hit};
			mlvl_reg  <= mpipe_reg[`STS_PIPE_STAGES-1];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			match_out <= 1'h0;
			mstr_reg  <= '0;
		end else if (clk_en) begin
			if (mstr_reg != '0) begin
				mstr_reg <= mstr_reg - 1'h1;
			end
			if (mlvl_reg && !match_out) begin
				match_out <= 1'h1;
				mstr_reg  <= `STS_STR_W'(`STS_MATCH_MIN_CYC - 1);
			end else if (!mlvl_reg && mstr_reg == '0) begin
				match_out <= 1'h0;
			end
		end
	end

	// selective acquisition blocks
	logic [`STS_NBLK-1:0]      open_reg, cpend_reg, wseen_reg, want;
	logic [`STS_SAMPLES_W-1:0] nleft_reg [`STS_NBLK];
	logic [`STS_REPEAT_W-1:0]  rep_reg [`STS_NBLK];

	for (genvar b = 0; b < `STS_NBLK; b++) begin : g_blk
		logic wh;
		assign wh = hit[blk_cfg[b].store_word];
		always_comb begin
			case (blk_cfg[b].store)
				`STS_STORE_ALL:   want[b] = 1'h1;
				`STS_STORE_WTHEN: want[b] = wseen_reg[b] || wh;
				`STS_STORE_WONLY: want[b] = wh;
				default:          want[b] = (nleft_reg[b] != '0) ||
				                            (wh && rep_reg[b] < blk_cfg[b].max_repeat
				                             && rep_reg[b] < `STS_REPEAT_MAX);
			endcase
		end
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				open_reg[b]  <= 1'h0;
				cpend_reg[b] <= 1'h0;
				wseen_reg[b] <= 1'h0;
				nleft_reg[b] <= '0;
				rep_reg[b]   <= '0;
			end else if (clk_en) begin
				if (acq_start) begin
					open_reg[b]  <= blk_cfg[b].enable && blk_cfg[b].open_src == `STS_OPEN_START;
					cpend_reg[b] <= 1'h0;
					wseen_reg[b] <= 1'h0;
					nleft_reg[b] <= '0;
					rep_reg[b]   <= '0;
				end else if (acq_end || (cpend_reg[b] && delay_done)) begin
					open_reg[b] <= 1'h0;
				end else if (smp && run_out) begin
					if (!open_reg[b] && blk_cfg[b].enable && blk_cfg[b].open_src == `STS_OPEN_WORD
					    && hit[blk_cfg[b].open_word]) begin
						open_reg[b] <= 1'h1;
					end else if (open_reg[b] && hit[blk_cfg[b].close_word]) begin
						if (blk_cfg[b].close_src == `STS_CLOSE_WORD) begin
							open_reg[b] <= 1'h0;
						end else if (blk_cfg[b].close_src == `STS_CLOSE_WDLY) begin
							cpend_reg[b] <= 1'h1;
						end
					end
					if (open_reg[b] && wh) begin
						wseen_reg[b] <= 1'h1;
					end
					if (open_reg[b] && blk_cfg[b].store == `STS_STORE_WN) begin
						if (nleft_reg[b] != '0) begin
							nleft_reg[b] <= nleft_reg[b] - 1'h1;
						end else if (want[b]) begin
							nleft_reg[b] <= blk_cfg[b].n_samples;
							rep_reg[b]   <= rep_reg[b] + 1'h1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			store_valid <= 1'h0;
			store_data  <= '0;
		end else if (clk_en) begin
			store_valid <= smp && run_out && ((open_reg & want) != '0);
			if (smp) begin
				store_data <= dat_s2_reg;
			end
		end
	end

	// interval counter while the chosen block is open
	logic cnt_tick;
	always_comb begin
		case (cnt_cfg.unit)
			`STS_UNIT_SAMPLES: cnt_tick = smp;
			`STS_UNIT_WORDS:   cnt_tick = smp && hit[cnt_cfg.word];
			default:           cnt_tick = clk_en;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			interval_count <= '0;
		end else if (clk_en) begin
			if (acq_start) begin
				interval_count <= '0;
			end else if (cnt_tick && open_reg[cnt_cfg.blk] && interval_count != '1) begin
				interval_count <= interval_count + 1'h1;
			end
		end
	end

endmodule

// File: tb/sts_sequencer_props.sv
/*
 * Port-level checker for the state trigger sequencer.
 * Assumes one ref_clk domain with synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "sts_map.svh"

module sts_sequencer_props (
	input wire logic                   ref_clk,
	input wire logic                   rst_n,
	input wire logic                   clk_en,
	input wire logic                   stop_btn,
	input wire logic                   start,
	input wire logic                   match_out,
	input wire logic                   run_out,
	input wire logic                   triggered,
	input wire logic                   store_valid,
	input wire logic [`STS_DLY_W-1:0]  interval_count
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_go;
		clk_en && start && !run_out;
	endsequence
	sequence s_stop;
		(clk_en && stop_btn) [*5];
	endsequence

	chk_run_starts: assert property (s_go |=> run_out && !triggered)
		else $error("run did not start after start");
	chk_run_cause: assert property ($rose(run_out) |-> $past(start))
		else $error("run rose without start");
	chk_trig_in_run: assert property ($rose(triggered) |-> $past(run_out))
		else $error("trigger outside acquisition");
	chk_trig_holds: assert property (triggered && !start |=> triggered)
		else $error("trigger dropped without start");
	chk_stop_ends: assert property (s_stop |-> !run_out)
		else $error("stop did not end acquisition");
	chk_match_width: assert property ($rose(match_out) |=> match_out)
		else $error("match pulse too short");
	chk_store_pulse: assert property (store_valid |=> !store_valid)
		else $error("store strobe longer than one cycle");
	chk_count_mono: assert property (!start |=> interval_count >= $past(interval_count))
		else $error("interval counter went down");
	chk_reset_clear: assert property ($rose(rst_n) |-> !run_out && !match_out
		&& !store_valid && interval_count == '0)
		else $error("outputs not clear after reset");
endmodule

bind sts_sequencer sts_sequencer_props sts_sequencer_props_inst (.ref_clk, .rst_n,
	.clk_en, .stop_btn, .start, .match_out, .run_out, .triggered, .store_valid,
	.interval_count);

// File: tb/sts_sut_model.sv
/*
 * System under test: drives state clock 0 and the sample word.
 * Assumes send() is called from one process at a time.
 */
`timescale 1ns/1ps
`include "sts_map.svh"

module sts_sut_model (
	input  wire logic                  ref_clk,
	output logic [`STS_NCLK-1:0]       sut_clk,
	output logic [`STS_DATA_W-1:0]     sut_data
);
	initial begin
		sut_clk = '0;
		sut_data = '0;
	end

	// clock idles low between samples; data turns over once hold has passed
	task automatic send(input logic [`STS_DATA_W-1:0] w, input int slow);
		@(negedge ref_clk);
		sut_data = w;
		repeat (2 + slow) @(negedge ref_clk);
		sut_clk[0] = 1'h1;
		repeat (2) @(negedge ref_clk);
		sut_clk[0] = 1'h0;
		@(negedge ref_clk);
		sut_data = ~w;
	endtask
endmodule

// File: tb/testbench.sv
/*
 * Self-checking bench for the state trigger sequencer.
 * Assumes the sut model drives state clock 0, sampled on its rising edge.
 */
`timescale 1ns/1ps
`include "sts_map.svh"

module testbench;
	logic ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1;
	logic ext_trig = 1'h1, stop_btn = 1'h0, start = 1'h0;
	logic [2:0] sut_clk;
	logic [34:0] sut_data, store_data, wa, wb;
	logic match_out, run_out, triggered, store_valid;
	logic [15:0] interval_count;
	sts_pkg::sts_word_t [`STS_NWORDS-1:0] word_cfg = '0;
	sts_pkg::sts_trig_t trig_cfg = '0;
	sts_pkg::sts_blk_t [`STS_NBLK-1:0] blk_cfg = '0;
	sts_pkg::sts_cnt_t cnt_cfg = '0;
	int bad_count = 0, num_checks = 0;
	logic [34:0] exp_q[$];
	logic keep = 1'h1;

	always #25 ref_clk = ~ref_clk;

	sts_sut_model sts_sut_model_inst (.ref_clk, .sut_clk, .sut_data);
	sts_sequencer sts_sequencer_inst (.ref_clk, .rst_n, .clk_en, .sut_clk, .sut_data,
		.ext_trig, .stop_btn, .start, .word_cfg, .trig_cfg, .blk_cfg, .cnt_cfg,
		.match_out, .run_out, .triggered, .store_valid, .store_data, .interval_count);

	task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// each stored sample must be the oldest word sent with keep set that is still queued
	always @(posedge ref_clk) begin
		if (store_valid === 1'h1) begin
			if (exp_q.size() == 0) check("store_valid", 1'h1, 1'h0);
			else check("store_data", store_data, exp_q.pop_front());
		end
	end

	function automatic logic [34:0] fil();
		return {2'h3, 33'($urandom())};
	endfunction

	task automatic setw(input int i, input logic [34:0] v, input logic [34:0] c,
		input logic f, input logic m);
		word_cfg[i] = '{v, c, f, 16'h0, m};
	endtask

	task automatic fresh();
		word_cfg = '0;
		trig_cfg = '0;
		trig_cfg.clk_sel = 3'h1;
		ext_trig = 1'h1;
	endtask

	task automatic arm(input logic [1:0] m, input int l, input int c, input int d);
		trig_cfg.mode = m;
		trig_cfg.last_idx = 3'(l);
		trig_cfg.trig_count = 16'(c);
		trig_cfg.dly_count = 16'(d);
		@(negedge ref_clk);
		start = 1'h1;
		@(negedge ref_clk);
		start = 1'h0;
		check("run_out", run_out, 1'h1);
	endtask

	task automatic play(input logic [34:0] w, input logic t);
		if (keep) exp_q.push_back(w);
		sts_sut_model_inst.send(w, int'($urandom_range(0, 3)));
		repeat (6) @(negedge ref_clk);
		check("triggered", triggered, t);
	endtask

	task automatic stop();
		stop_btn = 1'h1;
		repeat (6) @(negedge ref_clk);
		check("run_out", run_out, 1'h0);
		stop_btn = 1'h0;
		repeat (4) @(negedge ref_clk);
	endtask

	initial begin
		#2000000;
		bad_count++;
		$display("[ERR] watchdog expected end seen hang");
		print_verdict();
	end

	initial begin
		void'($urandom(89601));
		wa = {2'h0, 33'($urandom())};
		wb = {2'h1, 33'($urandom())};
		blk_cfg[0] = '{1'h1, `STS_OPEN_START, 3'h0, `STS_CLOSE_END, 3'h0, `STS_STORE_ALL,
			3'h0, 8'h0, 10'h200};
		repeat (20) @(negedge ref_clk);
		rst_n = 1'h1;
		for (int k = 0; k < 2; k++) begin
			fresh();
			setw(0, wa, '1, 1'h0, 1'h0);
			setw(1, wb, '1, 1'h0, 1'h0);
			arm(`STS_TMODE_PARALLEL, 1, 1, 0);
			play(fil(), 1'h0);
			play(k ? wb : wa, 1'h1);
			check("run_out", run_out, 1'h0);
		end
		$display("test parallel done");
		setw(0, wa, '1, 1'h1, 1'h0);
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		play(wa, 1'h0);
		play(fil(), 1'h1);
		$display("test false done");
		setw(0, wa, '1, 1'h0, 1'h0);
		arm(`STS_TMODE_SEQ, 1, 1, 0);
		play(wb, 1'h0);
		play(wa, 1'h0);
		play(fil(), 1'h0);
		play(wb, 1'h1);
		$display("test sequential done");
		arm(`STS_TMODE_IMMSEQ, 1, 1, 0);
		play(wa, 1'h0);
		play(fil(), 1'h0);
		play(wb, 1'h0);
		play(wa, 1'h0);
		play(wb, 1'h1);
		word_cfg[0].delay = 16'h1;
		arm(`STS_TMODE_SEQ, 1, 1, 0);
		play(wa, 1'h0);
		play(wb, 1'h0);
		play(wb, 1'h1);
		$display("test immediate done");
		arm(`STS_TMODE_PARALLEL, 0, 3, 0);
		play(wa, 1'h0);
		play(wa, 1'h0);
		play(fil(), 1'h0);
		play(wa, 1'h1);
		$display("test count done");
		arm(`STS_TMODE_PARALLEL, 0, 1, 2);
		play(wa, 1'h1);
		play(fil(), 1'h1);
		check("run_out", run_out, 1'h1);
		play(fil(), 1'h1);
		check("run_out", run_out, 1'h0);
		trig_cfg.dly_unit = `STS_UNIT_WORDS;
		trig_cfg.dly_word = 3'h1;
		arm(`STS_TMODE_PARALLEL, 0, 1, 1);
		play(wa, 1'h1);
		play(fil(), 1'h1);
		check("run_out", run_out, 1'h1);
		play(wb, 1'h1);
		check("run_out", run_out, 1'h0);
		$display("test delay done");
		fresh();
		ext_trig = 1'h0;
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		play(fil(), 1'h0);
		ext_trig = 1'h1;
		play(fil(), 1'h1);
		trig_cfg.ext_edge = 1'h1;
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		play(fil(), 1'h0);
		ext_trig = 1'h0;
		repeat (3) @(negedge ref_clk);
		ext_trig = 1'h1;
		play(fil(), 1'h1);
		fresh();
		setw(0, wa, '1, 1'h0, 1'h0);
		ext_trig = 1'h0;
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		play(wa, 1'h0);
		ext_trig = 1'h1;
		play(wa, 1'h1);
		$display("test external done");
		setw(0, wa, '1, 1'h0, 1'h1);
		ext_trig = 1'h0;
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		play(wb, 1'h0);
		for (int k = 0; k < 3; k++) play(fil(), 1'h0);
		check("match_out", match_out, 1'h0);
		play(wa, 1'h0);
		play(fil(), 1'h0);
		play(fil(), 1'h0);
		check("match_out", match_out, 1'h0);
		play(fil(), 1'h0);
		check("match_out", match_out, 1'h1);
		check("interval_count", interval_count, 35'h8);
		stop();
		check("triggered", triggered, 1'h0);
		$display("test match and stop done");
		fresh();
		setw(1, wa, '1, 1'h0, 1'h0);
		setw(2, wb, '1, 1'h0, 1'h0);
		blk_cfg[0] = '{1'h1, `STS_OPEN_WORD, 3'h1, `STS_CLOSE_WORD, 3'h2, `STS_STORE_WONLY,
			3'h1, 8'h0, 10'h0};
		ext_trig = 1'h0;
		arm(`STS_TMODE_PARALLEL, 0, 1, 0);
		keep = 1'h0;
		play(fil(), 1'h0);
		play(wa, 1'h0);
		keep = 1'h1;
		play(wa, 1'h0);
		keep = 1'h0;
		play(fil(), 1'h0);
		play(wb, 1'h0);
		play(wa, 1'h0);
		check("interval_count", interval_count, 35'h3);
		$display("test blocks done");
		repeat (10) @(negedge ref_clk);
		check("store_q", 35'(exp_q.size()), 35'h0);
		print_verdict();
	end
endmodule
